// file: core/cms_pkg.sv
// Functional notes
// - Wide decode compares the low eleven address lines, ignores the rest.
// - Narrow decode compares A0 to A9 only, space 0x000 to 0x3FF.
// - Without narrow jumper, A0 to A10 decoded, A11 to A15 ignored.
// - Narrow decode also exposes legacy burst registers through the index array.
// - No jumpers selects basic personality; personality jumper alone selects burst.
// - Burst personality interrupts per sample, or per burst with FIFO superset.
// - Burst personality always enables FIFO; status visible only with superset.
// - Superset jumper without third-mode jumper enables superset in both personalities.
// - Prefetch enable bit inserts a 2048-sample queue before the host bus.
// - Third-mode jumper alone selects the 12-bit personality, 8 or 16-bit bus.
// - Width jumper gives 16-bit output registers, else 12-bit legacy behaviour.
// - Filter jumper makes readout the average of the last sixteen samples.
// - Channel register write clears filter history; acquisition control unchanged.
// - Filtered readout lags sixteen samples per channel after clear or start.
// - Reset leaves channel register at zero and current channel zero.
// - Low channel above high channel does not wrap; only low is sampled.
// - Conversion indicator active while busy and on channel register write.
// - Counter outputs stay low until the counter has been programmed.
// - Host bus reset returns the counter unit to its initial state.
// - Both 8-bit and 16-bit host transactions are accepted.
// - 12-bit personality has no DMA; samples leave only by host reads.
// - Channel register is a byte at offset 2, readable and writable.
package cms_pkg;

    localparam logic [3:0]  CHAN_OFFSET    = 4'h2;
    localparam logic [3:0]  CTCFG_OFFSET   = 4'hF;
    localparam logic [7:0]  CHAN_RESET     = 8'h00;
    localparam int          CHAN_LO_LSB    = 0;
    localparam int          CHAN_HI_LSB    = 4;
    localparam logic [4:0]  FILTER_DEPTH   = 5'h10;
    localparam int          FILTER_SHIFT   = 4;
    localparam int          PREFETCH_DEPTH = 2048;
    localparam int          DAC_LEGACY_LSB = 4;
    localparam logic [1:0]  STRAP_WAIT     = 2'h3;
    localparam logic [15:0] BUS_ZERO       = 16'h0000;

    typedef enum logic [1:0] {
        PERS_BASIC,
        PERS_BURST,
        PERS_12BIT,
        PERS_NONE
    } cms_pers_type;

    typedef struct packed {
        logic third_mode_jumper;
        logic narrow_decode_jumper;
        logic filter_jumper;
        logic converter_width_jumper;
        logic fifo_superset_jumper;
        logic personality_jumper;
    } cms_jumper_type;

    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] wdata;
        logic        ior_n;
        logic        iow_n;
        logic        sbhe_n;
    } cms_hbus_type;

    typedef struct packed {
        logic irq_per_sample;
        logic irq_per_burst;
        logic fifo_enable;
        logic fifo_status_visible;
        logic superset_enable;
        logic dma_allowed;
        logic dac_16bit;
        logic indexed_burst_regs;
    } cms_mode_type;

endpackage : cms_pkg

// file: core/cms_hist_mem.sv
`timescale 1ns/1ps
module cms_hist_mem (
    input  wire logic        clk,
    input  wire logic        wr_en,
    input  wire logic [7:0]  wr_addr,
    input  wire logic [15:0] wr_data,
    input  wire logic [7:0]  rd_addr,
    output      logic [15:0] rd_data
);
    // No reset on the array: the per-channel fill count masks stale words.
    logic [15:0] mem [256];

    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule : cms_hist_mem

// file: core/cms_compat_core.sv
`timescale 1ns/1ps
module cms_compat_core (
    input  wire logic                clk,
    input  wire logic                rst_n,
    input  wire cms_pkg::cms_hbus_type hbus,
    input  wire cms_pkg::cms_jumper_type jumpers,
    input  wire logic [5:0]          base_jumpers,
    input  wire logic                prefetch_buffer_enable,
    input  wire logic                adc_busy,
    input  wire logic                adc_sample_valid,
    input  wire logic [15:0]         adc_sample,
    input  wire logic [15:0]         dac_code_in,
    input  wire logic [2:0]          ct_raw_out,
    output      logic [15:0]         rdata,
    output      logic [15:0]         rdata_oe,
    output      logic                conversion_indicator,
    output      logic [3:0]          current_channel,
    output      logic [15:0]         result,
    output      logic                result_valid,
    output      logic [3:0]          result_channel,
    output      logic [15:0]         dac_code_out,
    output      logic [2:0]          ct_out,
    output      logic                ct_reset,
    output      logic                prefetch_insert,
    output      cms_pkg::cms_pers_type personality,
    output      cms_pkg::cms_mode_type mode,
    output      logic                strap_ready
);
    import cms_pkg::*;

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    function automatic logic addr_hit(
        input logic [15:0] a,
        input logic [5:0]  base,
        input logic        narrow,
        input logic [3:0]  off
    );
        logic base_ok;
        base_ok = (a[9:4] == base) && (a[3:0] == off);
        if (narrow) begin
            addr_hit = base_ok;
        end else begin
            addr_hit = base_ok && !a[10];
        end
    endfunction : addr_hit

    function automatic cms_pers_type pers_decode(input cms_jumper_type j);
        if (!j.third_mode_jumper && !j.personality_jumper) begin
            pers_decode = PERS_BASIC;
        end else if (!j.third_mode_jumper) begin
            pers_decode = PERS_BURST;
        end else if (!j.fifo_superset_jumper && !j.personality_jumper) begin
            pers_decode = PERS_12BIT;
        end else begin
            pers_decode = PERS_NONE;
        end
    endfunction : pers_decode

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    cms_hbus_type   bus_s1_q;
    cms_hbus_type   bus_s2_q;
    cms_hbus_type   bus_s3_q;
    cms_hbus_type   bus_q;
    cms_jumper_type jmp_s1_q;
    cms_jumper_type jmp_s2_q;
    cms_jumper_type jmp_s3_q;
    logic [5:0]     base_s1_q;
    logic [5:0]     base_s2_q;
    logic [5:0]     base_s3_q;
    logic [2:0]     busy_s_q;
    logic           busy_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_s1_q <= '{addr: BUS_ZERO, wdata: BUS_ZERO,
                          ior_n: 1'b1, iow_n: 1'b1, sbhe_n: 1'b1};
            bus_s2_q <= '{addr: BUS_ZERO, wdata: BUS_ZERO,
                          ior_n: 1'b1, iow_n: 1'b1, sbhe_n: 1'b1};
            bus_s3_q <= '{addr: BUS_ZERO, wdata: BUS_ZERO,
                          ior_n: 1'b1, iow_n: 1'b1, sbhe_n: 1'b1};
            bus_q    <= '{addr: BUS_ZERO, wdata: BUS_ZERO,
                          ior_n: 1'b1, iow_n: 1'b1, sbhe_n: 1'b1};
        end else begin
            bus_s1_q <= hbus;
            bus_s2_q <= bus_s1_q;
            bus_s3_q <= bus_s2_q;
            if (bus_s2_q == bus_s3_q) begin
                bus_q <= bus_s3_q;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            jmp_s1_q  <= '0;
            jmp_s2_q  <= '0;
            jmp_s3_q  <= '0;
            base_s1_q <= '0;
            base_s2_q <= '0;
            base_s3_q <= '0;
            busy_s_q  <= '0;
            busy_q    <= 1'b0;
        end else begin
            jmp_s1_q  <= jumpers;
            jmp_s2_q  <= jmp_s1_q;
            jmp_s3_q  <= jmp_s2_q;
            base_s1_q <= base_jumpers;
            base_s2_q <= base_s1_q;
            base_s3_q <= base_s2_q;
            busy_s_q  <= {busy_s_q[1:0], adc_busy};
            if (busy_s_q[1] == busy_s_q[2]) begin
                busy_q <= busy_s_q[2];
            end
        end
    end

    // ------------------------------------------------------------
    // Strap capture
    // ------------------------------------------------------------
    // Jumpers are sampled once after release; moving one later is ignored
    // until the next reset.
    cms_jumper_type jmp_q;
    logic [5:0]     base_q;
    logic [1:0]     strap_cnt_q;
    logic           strap_q;
    cms_pers_type   pers_w;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            jmp_q       <= '0;
            base_q      <= '0;
            strap_cnt_q <= '0;
            strap_q     <= 1'b0;
        end else if (!strap_q) begin
            strap_cnt_q <= strap_cnt_q + 2'h1;
            if (strap_cnt_q == STRAP_WAIT && jmp_s2_q == jmp_s3_q
                && base_s2_q == base_s3_q) begin
                jmp_q   <= jmp_s3_q;
                base_q  <= base_s3_q;
                strap_q <= 1'b1;
            end
        end
    end

    assign pers_w = pers_decode(jmp_q);

    // ------------------------------------------------------------
    // Mode outputs
    // ------------------------------------------------------------
    cms_mode_type mode_d;
    logic         burst_w;
    logic         basic_w;

    assign burst_w = (pers_w == PERS_BURST);
    assign basic_w = (pers_w == PERS_BASIC);

    assign mode_d.irq_per_sample      = burst_w && !jmp_q.fifo_superset_jumper;
    assign mode_d.irq_per_burst       = burst_w && jmp_q.fifo_superset_jumper;
    assign mode_d.fifo_enable         = burst_w;
    assign mode_d.fifo_status_visible = burst_w && jmp_q.fifo_superset_jumper;
    assign mode_d.superset_enable     = (basic_w || burst_w)
                                        && jmp_q.fifo_superset_jumper;
    assign mode_d.dma_allowed         = strap_q && (pers_w != PERS_12BIT);
    assign mode_d.dac_16bit           = jmp_q.converter_width_jumper;
    assign mode_d.indexed_burst_regs  = jmp_q.narrow_decode_jumper;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode            <= '0;
            personality     <= PERS_BASIC;
            prefetch_insert <= 1'b0;
            strap_ready     <= 1'b0;
            dac_code_out    <= BUS_ZERO;
        end else begin
            mode            <= mode_d;
            personality     <= pers_w;
            prefetch_insert <= prefetch_buffer_enable;
            strap_ready     <= strap_q;
            if (jmp_q.converter_width_jumper) begin
                dac_code_out <= dac_code_in;
            end else begin
                dac_code_out <= {dac_code_in[15:DAC_LEGACY_LSB],
                                 4'h0};
            end
        end
    end

    // ------------------------------------------------------------
    // Host access
    // ------------------------------------------------------------
    logic         iow_prev_q;
    logic         wr_pulse_w;
    logic         chan_hit_w;
    logic         ctcfg_hit_w;
    logic         chan_wr_w;
    logic         rd_act_w;
    logic [7:0]   chan_q;
    logic [3:0]   lo_w;
    logic [3:0]   hi_w;

    assign wr_pulse_w  = strap_q && iow_prev_q && !bus_q.iow_n;
    assign chan_hit_w  = addr_hit(bus_q.addr, base_q,
                                  jmp_q.narrow_decode_jumper, CHAN_OFFSET);
    assign ctcfg_hit_w = addr_hit(bus_q.addr, base_q,
                                  jmp_q.narrow_decode_jumper, CTCFG_OFFSET);
    assign chan_wr_w   = wr_pulse_w && chan_hit_w;
    assign rd_act_w    = strap_q && !bus_q.ior_n && chan_hit_w;
    assign lo_w        = chan_q[CHAN_LO_LSB +: 4];
    assign hi_w        = chan_q[CHAN_HI_LSB +: 4];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            iow_prev_q <= 1'b1;
            chan_q     <= CHAN_RESET;
        end else begin
            iow_prev_q <= bus_q.iow_n;
            if (chan_wr_w) begin
                chan_q <= bus_q.wdata[7:0];
            end
        end
    end

    // The byte register sits on the low lane for both 8 and 16-bit cycles;
    // the high lane is driven zero only when the host asks for it.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata    <= BUS_ZERO;
            rdata_oe <= BUS_ZERO;
        end else begin
            rdata    <= rd_act_w ? {8'h00, chan_q} : BUS_ZERO;
            if (!rd_act_w) begin
                rdata_oe <= BUS_ZERO;
            end else if (!bus_q.sbhe_n) begin
                rdata_oe <= 16'hFFFF;
            end else begin
                rdata_oe <= 16'h00FF;
            end
        end
    end

    // ------------------------------------------------------------
    // Channel scan and conversion indicator
    // ------------------------------------------------------------
    logic [3:0] cur_q;
    logic [3:0] cur_d;

    always_comb begin
        cur_d = cur_q;
        if (chan_wr_w) begin
            cur_d = bus_q.wdata[CHAN_LO_LSB +: 4];
        end else if (adc_sample_valid) begin
            if (lo_w > hi_w) begin
                cur_d = lo_w;
            end else if (cur_q >= hi_w) begin
                cur_d = lo_w;
            end else begin
                cur_d = cur_q + 4'h1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cur_q                <= 4'h0;
            current_channel      <= 4'h0;
            conversion_indicator <= 1'b0;
        end else begin
            cur_q                <= cur_d;
            current_channel      <= cur_d;
            conversion_indicator <= busy_q || chan_wr_w;
        end
    end

    // ------------------------------------------------------------
    // Moving average filter
    // ------------------------------------------------------------
    // History is cleared by zeroing fill counts and sums, not the memory,
    // so a clear takes one cycle at the cost of 16 count registers.
    logic [19:0] sum_q [16];
    logic [3:0]  ptr_q [16];
    logic [4:0]  cnt_q [16];
    logic        p_v_q;
    logic [3:0]  p_ch_q;
    logic [15:0] p_data_q;
    logic [15:0] old_w;
    logic        full_w;
    logic [19:0] sum_w;

    cms_hist_mem u_hist (
        .clk     (clk),
        .wr_en   (p_v_q),
        .wr_addr ({p_ch_q, ptr_q[p_ch_q]}),
        .wr_data (p_data_q),
        .rd_addr ({cur_q, ptr_q[cur_q]}),
        .rd_data (old_w)
    );

    assign full_w = (cnt_q[p_ch_q] == FILTER_DEPTH);
    assign sum_w  = sum_q[p_ch_q] + {4'h0, p_data_q}
                    - (full_w ? {4'h0, old_w} : 20'h0_0000);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            p_v_q    <= 1'b0;
            p_ch_q   <= 4'h0;
            p_data_q <= BUS_ZERO;
        end else begin
            p_v_q    <= adc_sample_valid && !chan_wr_w;
            p_ch_q   <= cur_q;
            p_data_q <= adc_sample;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 16; i++) begin
                sum_q[i] <= 20'h0_0000;
                ptr_q[i] <= 4'h0;
                cnt_q[i] <= 5'h00;
            end
        end else if (chan_wr_w) begin
            for (int i = 0; i < 16; i++) begin
                sum_q[i] <= 20'h0_0000;
                ptr_q[i] <= 4'h0;
                cnt_q[i] <= 5'h00;
            end
        end else if (p_v_q) begin
            sum_q[p_ch_q] <= sum_w;
            ptr_q[p_ch_q] <= ptr_q[p_ch_q] + 4'h1;
            if (!full_w) begin
                cnt_q[p_ch_q] <= cnt_q[p_ch_q] + 5'h01;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            result         <= BUS_ZERO;
            result_valid   <= 1'b0;
            result_channel <= 4'h0;
        end else begin
            result_valid   <= p_v_q && !chan_wr_w;
            result_channel <= p_ch_q;
            if (jmp_q.filter_jumper) begin
                result <= sum_w[FILTER_SHIFT +: 16];
            end else begin
                result <= p_data_q;
            end
        end
    end

    // ------------------------------------------------------------
    // Counter outputs
    // ------------------------------------------------------------
    // The host bus reset is rst_n, so the counter unit restarts with it.
    logic ct_prog_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ct_prog_q <= 1'b0;
            ct_reset  <= 1'b1;
            ct_out    <= 3'h0;
        end else begin
            ct_reset <= !strap_q;
            if (wr_pulse_w && ctcfg_hit_w) begin
                ct_prog_q <= 1'b1;
            end
            ct_out <= ct_prog_q ? ct_raw_out : 3'h0;
        end
    end

endmodule : cms_compat_core

// file: bench/cms_compat_properties.sv
`timescale 1ns/1ps
// ----------------------------------------
// Port checker
// ----------------------------------------
module cms_compat_props (
    input wire logic                  clk,
    input wire logic                  rst_n,
    input wire cms_pkg::cms_hbus_type hbus,
    input wire logic                  adc_busy,
    input wire logic                  adc_sample_valid,
    input wire logic                  prefetch_buffer_enable,
    input wire logic [15:0]           rdata,
    input wire logic [15:0]           rdata_oe,
    input wire logic                  conversion_indicator,
    input wire logic                  result_valid,
    input wire logic [15:0]           dac_code_out,
    input wire logic [2:0]            ct_out,
    input wire logic                  ct_reset,
    input wire logic                  prefetch_insert,
    input wire cms_pkg::cms_pers_type personality,
    input wire cms_pkg::cms_mode_type mode,
    input wire logic                  strap_ready
);
    import cms_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_busy_run;
        adc_busy [*6];
    endsequence
    // A write strobe still in the synchroniser may drop the sample.
    sequence s_quiet_sample;
        hbus.iow_n [*8] ##1 adc_sample_valid && hbus.iow_n;
    endsequence
    strap_ct_a: assert property (!strap_ready |-> ct_reset)
        else $error("counter unit left reset before straps");
    ct_idle_a: assert property (ct_reset |-> ct_out == 3'h0)
        else $error("counter outputs not low");
    read_byte_a: assert property (rdata_oe != 16'h0000 |-> rdata[15:8] == 8'h00)
        else $error("channel read upper byte not zero");
    lane_oe_a: assert property (rdata_oe inside {16'h0000, 16'h00FF, 16'hFFFF})
        else $error("bad byte lane enable");
    dac_legacy_a: assert property (strap_ready && !mode.dac_16bit |-> dac_code_out[3:0] == 4'h0)
        else $error("legacy output low nibble not zero");
    sample_res_a: assert property (s_quiet_sample |-> ##2 result_valid)
        else $error("sample gave no result");
    no_dma_a: assert property (personality == PERS_12BIT |-> !mode.dma_allowed)
        else $error("dma allowed in 12-bit personality");
    burst_irq_a: assert property (personality == PERS_BURST |-> mode.fifo_enable && (mode.irq_per_sample != mode.irq_per_burst))
        else $error("burst personality mode bits wrong");
    pers_hold_a: assert property (strap_ready && $past(strap_ready) |-> $stable(personality) && $stable(mode))
        else $error("personality changed in operation");
    busy_ind_a: assert property (s_busy_run |-> conversion_indicator)
        else $error("indicator low while busy");
    prefetch_a: assert property ($past(rst_n) |-> prefetch_insert == $past(prefetch_buffer_enable))
        else $error("prefetch insert does not follow enable");
endmodule : cms_compat_props

bind cms_compat_core cms_compat_props u_props (
    .clk(clk), .rst_n(rst_n), .hbus(hbus), .adc_busy(adc_busy),
    .adc_sample_valid(adc_sample_valid), .prefetch_buffer_enable(prefetch_buffer_enable),
    .rdata(rdata), .rdata_oe(rdata_oe), .conversion_indicator(conversion_indicator),
    .result_valid(result_valid), .dac_code_out(dac_code_out), .ct_out(ct_out),
    .ct_reset(ct_reset), .prefetch_insert(prefetch_insert), .personality(personality),
    .mode(mode), .strap_ready(strap_ready)
);

// file: bench/cms_host_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Host bus master
// ----------------------------------------
module cms_host_model (
    input  wire logic                 clk,
    input  wire logic [15:0]          rdata,
    input  wire logic [15:0]          rdata_oe,
    output var cms_pkg::cms_hbus_type hbus
);
    import cms_pkg::*;
    // Strobes stay long enough to clear the three-stage pin synchroniser.
    localparam int HOLD = 8;
    initial hbus = '{addr: 16'h0000, wdata: 16'hFFFF, ior_n: 1'b1, iow_n: 1'b1, sbhe_n: 1'b1};
    task automatic io_write(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        #5;
        hbus.addr = a;
        hbus.wdata = {8'h00, d};
        hbus.sbhe_n = 1'b1;
        hbus.iow_n = 1'b0;
        repeat (HOLD) @(posedge clk);
        #5;
        hbus.iow_n = 1'b1;
        repeat (HOLD) @(posedge clk);
        #5;
        hbus.wdata = ~hbus.wdata;
    endtask : io_write
    task automatic io_read(input logic [15:0] a, input logic wide,
                           output logic [15:0] d, output logic [15:0] oe);
        @(posedge clk);
        #5;
        hbus.addr = a;
        hbus.sbhe_n = !wide;
        hbus.ior_n = 1'b0;
        repeat (HOLD) @(posedge clk);
        #5;
        d = rdata;
        oe = rdata_oe;
        hbus.ior_n = 1'b1;
        repeat (HOLD) @(posedge clk);
    endtask : io_read
endmodule : cms_host_model

// file: bench/compat_mode_select_and_filter_tb.sv
`timescale 1ns/1ps
module compat_mode_select_and_filter_tb;
    import cms_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    cms_hbus_type hbus;
    cms_jumper_type jumpers = '0;
    logic [5:0] base_jumpers = 6'h30;
    logic pf_en = 1'b0;
    logic adc_busy = 1'b0;
    logic vld = 1'b0;
    logic [15:0] smp = 16'h0000;
    logic [15:0] dac_in = 16'h1234;
    logic [2:0] ct_raw = 3'h7;
    logic [15:0] rdata, rdata_oe, result, dac_out, d, oe;
    logic conv, result_valid, ct_reset, pf_ins, strap_ready;
    logic [3:0] cur_ch, res_ch;
    logic [2:0] ct_out;
    cms_pers_type pers;
    cms_mode_type mode;
    int n_errors = 0;
    int n_checks = 0;
    int n_ind = 0;
    logic [5:0] jm [7] = '{6'h00, 6'h01, 6'h03, 6'h02, 6'h20, 6'h14, 6'h21};
    cms_pers_type pe [7] = '{PERS_BASIC, PERS_BURST, PERS_BURST, PERS_BASIC,
                             PERS_12BIT, PERS_BASIC, PERS_NONE};
    logic [7:0] me [7] = '{8'h00, 8'hA0, 8'h78, 8'h08, 8'h00, 8'h07, 8'h04};
    always #25 clk = ~clk;
    always @(posedge clk) if (conv === 1'b1) n_ind <= n_ind + 1;
    cms_host_model host (.clk(clk), .rdata(rdata), .rdata_oe(rdata_oe), .hbus(hbus));
    cms_compat_core dut (
        .clk(clk), .rst_n(rst_n), .hbus(hbus), .jumpers(jumpers),
        .base_jumpers(base_jumpers), .prefetch_buffer_enable(pf_en), .adc_busy(adc_busy),
        .adc_sample_valid(vld), .adc_sample(smp), .dac_code_in(dac_in), .ct_raw_out(ct_raw),
        .rdata(rdata), .rdata_oe(rdata_oe), .conversion_indicator(conv),
        .current_channel(cur_ch), .result(result), .result_valid(result_valid),
        .result_channel(res_ch), .dac_code_out(dac_out), .ct_out(ct_out), .ct_reset(ct_reset),
        .prefetch_insert(pf_ins), .personality(pers), .mode(mode), .strap_ready(strap_ready)
    );
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : wrap_up
    task automatic do_reset(input logic [5:0] j);
        int k;
        @(posedge clk);
        #5;
        rst_n = 1'b0;
        jumpers = cms_jumper_type'(j);
        repeat (2) @(posedge clk);
        #5;
        check(16'({ct_reset, pers}), 16'h0004);
        rst_n = 1'b1;
        for (k = 0; k < 20 && strap_ready !== 1'b1; k++) @(posedge clk);
        #5;
        if (strap_ready !== 1'b1) begin
            n_errors++;
            wrap_up();
        end
    endtask : do_reset
    task automatic send(input logic [15:0] v, input logic [15:0] exp);
        @(posedge clk);
        #5;
        smp = v;
        vld = 1'b1;
        @(posedge clk);
        #5;
        vld = 1'b0;
        @(posedge clk);
        #5;
        check(16'(result_valid), 16'h0001);
        check(result, exp);
    endtask : send
    initial begin
        int i, c0;
        do_reset(6'h00);
        host.io_read(16'h0302, 1'b0, d, oe);
        check(d, 16'h0000);
        check(oe, 16'h00FF);
        check(16'(cur_ch), 16'h0000);
        check(16'(ct_out), 16'h0000);
        host.io_write(16'h030F, 8'h00);
        check(16'(ct_out), 16'h0007);
        $display("test reset and counter done");
        c0 = n_ind;
        host.io_write(16'h0302, 8'h03);
        check(16'(n_ind - c0), 16'h0001);
        host.io_read(16'h0302, 1'b0, d, oe);
        check(d, 16'h0003);
        for (i = 0; i < 2; i++) begin
            send(16'h1234, 16'h1234);
            check(16'(cur_ch), 16'h0003);
        end
        host.io_write(16'h0302, 8'h52);
        check(16'(cur_ch), 16'h0002);
        for (i = 3; i < 7; i++) begin
            send(16'h00A5, 16'h00A5);
            check(16'(res_ch), 16'(i - 1));
            check(16'(cur_ch), 16'((i > 5) ? 2 : i));
        end
        adc_busy = 1'b1;
        repeat (7) @(posedge clk);
        #5;
        check(16'(conv), 16'h0001);
        adc_busy = 1'b0;
        $display("test scan done");
        host.io_write(16'hF302, 8'h11);
        host.io_read(16'h0302, 1'b1, d, oe);
        check(d, 16'h0011);
        check(oe, 16'hFFFF);
        host.io_read(16'h0702, 1'b0, d, oe);
        check(oe, 16'h0000);
        host.io_read(16'h0305, 1'b0, d, oe);
        check(oe, 16'h0000);
        do_reset(6'h10);
        host.io_write(16'h0702, 8'h44);
        host.io_read(16'hFF02, 1'b0, d, oe);
        check(d, 16'h0044);
        $display("test decode done");
        do_reset(6'h08);
        host.io_write(16'h0302, 8'h00);
        for (i = 1; i < 18; i++) send(16'h0100, 16'(((i > 16) ? 16 : i) * 16));
        host.io_write(16'h0302, 8'h00);
        send(16'h0100, 16'h0010);
        $display("test filter done");
        for (i = 0; i < 7; i++) begin
            do_reset(jm[i]);
            check(16'(pers), 16'(pe[i]));
            check(16'(mode & ((i > 3) ? 8'hFF : 8'hFB)), 16'(me[i]));
            check(dac_out, jm[i][2] ? 16'h1234 : 16'h1230);
        end
        jumpers = cms_jumper_type'(6'h01);
        pf_en = 1'b1;
        repeat (8) @(posedge clk);
        #5;
        check(16'(pers), 16'(PERS_NONE));
        check(16'(pf_ins), 16'h0001);
        $display("test personality done");
        wrap_up();
    end
endmodule : compat_mode_select_and_filter_tb
